// ### logic/flash_id_auth_guard.sv
// Flash access guard: settings intake, ID authentication and erase control.
`timescale 1ns/1ns
module flash_id_auth_guard (
  input  wire logic       clock_i,         // Device clock, 50 MHz.
  input  wire logic       rstn_i,          // Asynchronous reset, active low.
  input  wire logic       set_valid_i,     // Settings byte present.
  input  wire logic [7:0] set_byte_i,      // Settings byte, control first, then ID, then ROM.
  output logic            set_done_o,      // All settings taken in.
  input  wire logic       boot_connect_i,  // Boot-mode host connects (pulse).
  input  wire logic       dbg_connect_i,   // Debugger connects (pulse).
  input  wire logic       code_valid_i,    // Supplied code byte present.
  input  wire logic [7:0] code_byte_i,     // Supplied code byte, first ID byte first.
  output logic            code_ready_o,    // Guard takes a code byte.
  output logic            auth_fail_o,     // Attempt rejected (pulse).
  output logic            boot_access_o,   // Boot host may read, program and erase.
  output logic            dbg_link_o,      // Debugger connection established.
  output logic            erase_req_o,     // Whole-array erase request, held until done.
  input  wire logic       erase_done_i,    // Erase finished (pulse).
  input  wire logic       pp_req_i,        // Parallel programmer request (pulse).
  output logic            pp_allow_o,      // Parallel programmer access allowed.
  output logic            pp_refuse_o      // Programmer request refused (pulse).
);
  typedef enum logic [2:0] {ST_LOAD, ST_IDLE, ST_CODE, ST_CMP, ST_ERASE, ST_OPEN} state_e;

  state_e     state_q;      // Guard state.
  logic [4:0] load_idx_q;   // Next settings byte index.
  logic [7:0] ctrl_q;       // Stored control code.
  logic       rsv_id_q;     // ID equals the reserved sequence so far.
  logic       rom_zero_q;   // ROM code bytes all zero so far.
  logic [3:0] code_idx_q;   // Next supplied ID byte index.
  logic [7:0] code_q;       // Supplied byte under comparison.
  logic       mism_q;       // A byte of this attempt differed.
  logic       dbg_q;        // Current attempt is from the debugger.
  logic       open_after_q; // Erase was the boot-entry kind, open access afterwards.
  logic [1:0] fail_cnt_q;   // Consecutive boot failures under code 45h.
  logic       fail_q;       // Rejection pulse register.
  logic       dbg_link_q;   // Debugger link register.
  logic       refuse_q;     // Programmer refusal pulse register.

  settings_mem_if mem_bus ();

  settings_mem u_settings_mem (
    .clock_i (clock_i),
    .bus     (mem_bus)
  );

  // Settings intake writes the store; comparison reads the ID bytes.
  // three stored settings
  assign mem_bus.we    = (state_q == ST_LOAD) && set_valid_i;
  assign mem_bus.waddr = load_idx_q;
  assign mem_bus.wdata = set_byte_i;
  assign mem_bus.raddr = flash_guard_pkg::ID_BASE + {1'b0, code_idx_q};

  logic       in_id;     // Intake is within the ID bytes.
  logic [4:0] id_off_w;  // ID offset of the byte being taken in.
  assign id_off_w = load_idx_q - flash_guard_pkg::ID_BASE;
  assign in_id    = (load_idx_q >= flash_guard_pkg::ID_BASE) && (load_idx_q < flash_guard_pkg::ROM_BASE);

  // Comparison outcome of each byte and of the last byte of an attempt.
  logic lock_rsv;   // Reserved pairing: nothing ever matches.
  logic byte_bad;   // Byte under comparison differs.
  logic last_cmp;   // Comparing the final byte.
  logic attempt_ok; // Whole attempt matched.
  logic boot_fail;  // Boot attempt failed now.
  logic third_fail; // This boot failure erases the array.
  assign lock_rsv   = (ctrl_q == flash_guard_pkg::CTRL_AUTH_RETRY) && rsv_id_q;
  // The stored byte was fetched while the guard waited for the code byte, so both stand here.
  assign byte_bad   = (mem_bus.rdata != code_q);
  assign last_cmp   = (state_q == ST_CMP) && (code_idx_q == flash_guard_pkg::ID_LAST);
  assign attempt_ok = last_cmp && !mism_q && !byte_bad && !lock_rsv;
  assign boot_fail  = last_cmp && !attempt_ok && !dbg_q;
  assign third_fail = boot_fail && (ctrl_q == flash_guard_pkg::CTRL_AUTH_ERASE)
                      && (fail_cnt_q == flash_guard_pkg::FAIL_LIMIT - 2'h1);

  // Settings intake: capture control code and decode ID and ROM patterns on the fly.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      load_idx_q <= 5'h00;
      ctrl_q     <= 8'h00;
      rsv_id_q   <= 1'b1;
      rom_zero_q <= 1'b1;
    end
    else if ((state_q == ST_LOAD) && set_valid_i)
    begin
      load_idx_q <= load_idx_q + 5'h01;
      if (load_idx_q == flash_guard_pkg::CTRL_IDX)
      begin
        ctrl_q <= set_byte_i;
      end
      else if (in_id)
      begin
        rsv_id_q <= rsv_id_q && (set_byte_i == flash_guard_pkg::reserved_byte(id_off_w[3:0]));
      end
      else
      begin
        rom_zero_q <= rom_zero_q && (set_byte_i == flash_guard_pkg::ROM_LOCK_BYTE);
      end
    end
  end

  // Main sequencing of connections, attempts and erasure.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q      <= ST_LOAD;
      code_idx_q   <= 4'h0;
      code_q       <= 8'h00;
      mism_q       <= 1'b0;
      dbg_q        <= 1'b0;
      open_after_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_LOAD:
        begin
          if (set_valid_i && (load_idx_q == flash_guard_pkg::SET_LAST))
          begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          // Boot wins when both parties connect in the same cycle.
          if (boot_connect_i)
          begin
            dbg_q <= 1'b0;
            if (flash_guard_pkg::auth_required(ctrl_q))
            begin
              state_q <= ST_CODE;
            end
            else
            begin
              open_after_q <= 1'b1;
              state_q      <= ST_ERASE;
            end
          end
          else if (dbg_connect_i && flash_guard_pkg::auth_required(ctrl_q))
          begin
            dbg_q   <= 1'b1;
            state_q <= ST_CODE;
          end
        end
        ST_CODE:
        begin
          if (code_valid_i)
          begin
            code_q  <= code_byte_i;
            state_q <= ST_CMP;
          end
        end
        ST_CMP:
        begin
          if (!last_cmp)
          begin
            mism_q     <= mism_q || byte_bad;
            code_idx_q <= code_idx_q + 4'h1;
            state_q    <= ST_CODE;
          end
          else
          begin
            mism_q     <= 1'b0;
            code_idx_q <= 4'h0;
            if (attempt_ok && !dbg_q)
            begin
              state_q <= ST_OPEN;
            end
            else if (attempt_ok)
            begin
              state_q <= ST_IDLE;
            end
            else if (third_fail)
            begin
              open_after_q <= 1'b0;
              state_q      <= ST_ERASE;
            end
            else
            begin
              state_q <= ST_CODE;
            end
          end
        end
        ST_ERASE:
        begin
          if (erase_done_i)
          begin
            state_q <= open_after_q ? ST_OPEN : ST_IDLE;
          end
        end
        ST_OPEN:
        begin
          state_q <= ST_OPEN;
        end
        default:
        begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end

  // Consecutive boot failure count, only kept under code 45h.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fail_cnt_q <= 2'h0;
    end
    else if (last_cmp && !dbg_q)
    begin
      if (attempt_ok || third_fail || (ctrl_q != flash_guard_pkg::CTRL_AUTH_ERASE))
      begin
        fail_cnt_q <= 2'h0;
      end
      else
      begin
        fail_cnt_q <= fail_cnt_q + 2'h1;
      end
    end
  end

  // Outcome pulses and the debugger link.
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fail_q     <= 1'b0;
      dbg_link_q <= 1'b0;
      refuse_q   <= 1'b0;
    end
    else
    begin
      fail_q   <= last_cmp && !attempt_ok;
      refuse_q <= pp_req_i && !pp_allow_o;
      if ((state_q == ST_IDLE) && !boot_connect_i && dbg_connect_i && !flash_guard_pkg::auth_required(ctrl_q))
      begin
        dbg_link_q <= 1'b1;
      end
      else if (attempt_ok && dbg_q)
      begin
        dbg_link_q <= 1'b1;
      end
    end
  end

  assign set_done_o    = (state_q != ST_LOAD);
  assign code_ready_o  = (state_q == ST_CODE);
  assign auth_fail_o   = fail_q;
  assign boot_access_o = (state_q == ST_OPEN);
  assign dbg_link_o    = dbg_link_q;
  assign erase_req_o   = (state_q == ST_ERASE);
  assign pp_allow_o    = set_done_o && !rom_zero_q;
  assign pp_refuse_o   = refuse_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  AST_PP_REFUSE: assert property (pp_req_i && set_done_o && rom_zero_q |=> pp_refuse_o)
    else $error("Programmer request not refused under ROM lock.");
  AST_PP_LOCKED: assert property (set_done_o && rom_zero_q |-> !pp_allow_o)
    else $error("Programmer allowed under ROM lock.");
  AST_BOOT_OPEN: assert property (attempt_ok && !dbg_q |=> boot_access_o && !erase_req_o)
    else $error("Boot match did not open access.");
  AST_BOOT_RETRY: assert property (boot_fail && !third_fail |=> code_ready_o && auth_fail_o && !boot_access_o)
    else $error("Boot mismatch did not return to code intake.");
  AST_THIRD_ERASE: assert property (third_fail |=> erase_req_o && (fail_cnt_q == 2'h0))
    else $error("Third boot failure did not erase.");
  AST_DBG_LINK: assert property ($rose(dbg_link_o) |-> $past(attempt_ok && dbg_q)
                                 || !flash_guard_pkg::auth_required(ctrl_q))
    else $error("Debugger linked without matching code.");
  AST_DBG_NO_ERASE: assert property (last_cmp && dbg_q && !attempt_ok |=> code_ready_o && !erase_req_o)
    else $error("Debugger mismatch erased or left intake.");
  AST_RETRY_NO_ERASE: assert property (ctrl_q == flash_guard_pkg::CTRL_AUTH_RETRY |-> !erase_req_o)
    else $error("Erase requested under retry code.");
  AST_NO_COUNT: assert property (ctrl_q == flash_guard_pkg::CTRL_AUTH_RETRY |-> fail_cnt_q == 2'h0)
    else $error("Failure count kept under retry code.");
  AST_OPEN_ERASE: assert property (state_q == ST_IDLE && boot_connect_i && !flash_guard_pkg::auth_required(ctrl_q)
                                   |=> erase_req_o)
    else $error("Unprotected boot entry did not erase.");
  AST_AUTH_ENTRY: assert property (state_q == ST_IDLE && boot_connect_i
                                   && ctrl_q == flash_guard_pkg::CTRL_AUTH_ERASE |=> code_ready_o)
    else $error("Code 45h boot entry skipped authentication.");
  AST_RSV_LOCK: assert property (set_done_o && lock_rsv |-> !boot_access_o && !attempt_ok)
    else $error("Reserved pairing let access through.");

  COV_BOOT_OPEN: cover property (attempt_ok && !dbg_q);
  COV_THIRD_ERASE: cover property (third_fail ##1 erase_req_o [*2]);
  COV_DBG_LINK: cover property ($rose(dbg_link_o));
endmodule // flash_id_auth_guard

// ### logic/flash_guard_pkg.sv
// Constants and helpers shared by the flash access guard.
package flash_guard_pkg;
  localparam logic [7:0] CTRL_AUTH_ERASE = 8'h45;  // Authenticate, erase after repeated boot failures.
  localparam logic [7:0] CTRL_AUTH_RETRY = 8'h52;  // Authenticate, retry without limit.
  localparam logic [7:0] ROM_LOCK_BYTE   = 8'h00;  // Every ROM code byte at this value locks the programmer.
  localparam logic [7:0] RSV_FILL_BYTE   = 8'hff;  // Fill of the reserved ID sequence after its prefix.
  localparam logic [4:0] CTRL_IDX        = 5'h00;  // Settings byte holding the control code.
  localparam logic [4:0] ID_BASE         = 5'h01;  // First of fifteen ID code bytes.
  localparam logic [4:0] ROM_BASE        = 5'h10;  // First of four ROM code bytes.
  localparam logic [4:0] SET_LAST        = 5'h13;  // Last settings byte.
  localparam logic [3:0] ID_LAST         = 4'he;   // Index of the last ID byte.
  localparam logic [1:0] FAIL_LIMIT      = 2'h3;   // Consecutive boot failures that trigger erasure.
  localparam int         SET_DEPTH       = 20;     // Bytes of stored settings.

  // True when the control code asks for ID authentication.
  function automatic logic auth_required(input logic [7:0] ctrl);
    auth_required = (ctrl == CTRL_AUTH_ERASE) || (ctrl == CTRL_AUTH_RETRY);
  endfunction

  // Byte of the reserved ID sequence at a given ID index.
  function automatic logic [7:0] reserved_byte(input logic [3:0] idx);
    case (idx)
      4'h0:    reserved_byte = 8'h50;
      4'h1:    reserved_byte = 8'h72;
      4'h2:    reserved_byte = 8'h6f;
      4'h3:    reserved_byte = 8'h74;
      4'h4:    reserved_byte = 8'h65;
      4'h5:    reserved_byte = 8'h63;
      4'h6:    reserved_byte = 8'h74;
      default: reserved_byte = RSV_FILL_BYTE;
    endcase
  endfunction
endpackage

// ### logic/settings_mem_if.sv
// Port bundle between the guard and its settings store.
`timescale 1ns/1ns
interface settings_mem_if;
  logic       we;     // Write strobe.
  logic [4:0] waddr;  // Write byte index.
  logic [7:0] wdata;  // Write byte.
  logic [4:0] raddr;  // Read byte index.
  logic [7:0] rdata;  // Registered read byte.
  modport ctrl (output we, waddr, wdata, raddr, input rdata);
  modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface

// ### logic/settings_mem.sv
// Small byte store for the protection settings with a registered read port.
`timescale 1ns/1ns
module settings_mem (
  input  wire logic     clock_i,  // Device clock.
  settings_mem_if.mem   bus       // Read and write port.
);
  logic [7:0] store_q [flash_guard_pkg::SET_DEPTH];  // Settings bytes; no reset, loaded before use.
  logic [7:0] rdata_q;                               // Read data register.

  // Write port; the store is only written while settings are being loaded.
  always_ff @(posedge clock_i)
  begin
    if (bus.we)
    begin
      store_q[bus.waddr] <= bus.wdata;
    end
  end

  // Read port, one cycle of latency so the store maps onto a register file.
  always_ff @(posedge clock_i)
  begin
    rdata_q <= store_q[bus.raddr];
  end

  assign bus.rdata = rdata_q;
endmodule // settings_mem

// ### tb/flash_host_model.sv
// Behavioural boot host or debugger plus flash eraser facing the access guard.
`timescale 1ns/1ns
module flash_host_model #(
  parameter int ERASE_WAIT = 5  // Cycles the flash array needs to erase.
) (
  input  wire logic       clock_i,       // Device clock.
  input  wire logic       code_ready_i,  // Guard takes a code byte.
  output logic            code_valid_o,  // Code byte present.
  output logic [7:0]      code_byte_o,   // Code byte.
  input  wire logic       erase_req_i,   // Whole-array erase request.
  output logic            erase_done_o   // Erase finished pulse.
);
  int unsigned wait_q;  // Erase progress counter.

  // Nothing is offered and nothing is erasing at time zero.
  initial
  begin
    code_valid_o = 1'b0;
    code_byte_o  = 8'h00;
    erase_done_o = 1'b0;
    wait_q       = 0;
  end

  // full code resubmitted
  // Every attempt is a whole 15-byte code; a retry is simply another call. A released line shows the
  // inverse of its last byte so that stale data is never mistaken for a fresh byte.
  task automatic send(input logic [119:0] code, input int gap, output int hung);
    int n;
    hung = 0;
    for (int i = 0; i < 15; i++)
    begin
      repeat (gap + 1) @(posedge clock_i);
      code_valid_o <= 1'b1;
      code_byte_o  <= code[119-8*i-:8];
      n = 0;
      do
      begin
        @(posedge clock_i);
        n++;
      end while (code_ready_i !== 1'b1 && n < 200);
      code_valid_o <= 1'b0;
      code_byte_o  <= ~code[119-8*i-:8];
      if (n >= 200)
      begin
        hung = 1;
        return;
      end
    end
  endtask

  // The erase takes a fixed time and ends with one done pulse; the guard drops its request after it.
  always @(posedge clock_i)
  begin
    erase_done_o <= 1'b0;
    if (erase_req_i && !erase_done_o)
    begin
      wait_q <= wait_q + 1;
      if (wait_q == ERASE_WAIT)
      begin
        erase_done_o <= 1'b1;
        wait_q       <= 0;
      end
    end
  end
endmodule  // flash_host_model

// ### tb/tb_flash_id_auth_guard.sv
// Self-checking testbench for the flash access guard.
`timescale 1ns/1ns
module tb_flash_id_auth_guard;
  logic       clock_i, rstn_i, set_valid_i, boot_connect_i, dbg_connect_i, pp_req_i;  // Bench-driven inputs.
  logic [7:0] set_byte_i;                                                             // Settings byte.
  logic       code_valid_i, erase_done_i, set_done_o, code_ready_o, auth_fail_o;      // Handshake lines.
  logic       boot_access_o, dbg_link_o, erase_req_o, pp_allow_o, pp_refuse_o;        // Guard outcomes.
  logic [7:0] code_byte_i;                                                            // Supplied code byte.
  int         n_fail, n_tests;                                                        // Run counters.
  localparam logic [119:0] ID_A = 120'h0102030405060708090a0b0c0d0e0f;  // Stored developer code.
  localparam logic [119:0] ID_B = ID_A ^ 120'h1;                        // Differs only in its last byte.
  localparam logic [119:0] RSV  = {56'h50726f74656374, {8{8'hff}}};     // Reserved permanent-lock code.

  flash_id_auth_guard i_flash_id_auth_guard (.clock_i(clock_i), .rstn_i(rstn_i), .set_valid_i(set_valid_i),
    .set_byte_i(set_byte_i), .set_done_o(set_done_o), .boot_connect_i(boot_connect_i),
    .dbg_connect_i(dbg_connect_i), .code_valid_i(code_valid_i), .code_byte_i(code_byte_i),
    .code_ready_o(code_ready_o), .auth_fail_o(auth_fail_o), .boot_access_o(boot_access_o),
    .dbg_link_o(dbg_link_o), .erase_req_o(erase_req_o), .erase_done_i(erase_done_i), .pp_req_i(pp_req_i),
    .pp_allow_o(pp_allow_o), .pp_refuse_o(pp_refuse_o));

  flash_host_model i_flash_host_model (.clock_i(clock_i), .code_ready_i(code_ready_o),
    .code_valid_o(code_valid_i), .code_byte_o(code_byte_i), .erase_req_i(erase_req_o),
    .erase_done_o(erase_done_i));

  // A 20 ns clock; every bench input has a value at time zero.
  initial
  begin
    {clock_i, rstn_i, set_valid_i, boot_connect_i, dbg_connect_i, pp_req_i, set_byte_i} = '0;
    forever #10 clock_i = ~clock_i;
  end

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Resets for two cycles, then streams control, ID and ROM bytes back to back.
  task automatic load(input logic [7:0] ctrl, input logic [119:0] id, input logic [31:0] rom);
    logic [159:0] s;
    s = {ctrl, id, rom};
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 20; i++)
    begin
      set_valid_i <= 1'b1;
      set_byte_i  <= s[159-8*i-:8];
      @(posedge clock_i);
    end
    set_valid_i <= 1'b0;
    @(posedge clock_i);
    #1 chk(set_done_o, 1);
  endtask

  // One-cycle connect pulse; returns just after the edge that samples it.
  task automatic connect(input logic boot);
    @(posedge clock_i);
    boot_connect_i <= boot;
    dbg_connect_i  <= !boot;
    @(posedge clock_i);
    boot_connect_i <= 1'b0;
    dbg_connect_i  <= 1'b0;
    #1;
  endtask

  // Sends one whole code and stops in the one cycle in which the rejection pulse stands.
  task automatic try_code(input logic [119:0] code, input int gap);
    int hung;
    i_flash_host_model.send(code, gap, hung);
    if (hung != 0)
      chk(1, 0);
    @(posedge clock_i);
    #1;
  endtask

  // Programmer request pulse; the refusal is looked for on the two edges after it.
  task automatic pp_try(input logic refuse);
    logic seen;
    seen = 1'b0;
    @(posedge clock_i);
    pp_req_i <= 1'b1;
    @(posedge clock_i);
    pp_req_i <= 1'b0;
    repeat (2)
    begin
      #1 seen = seen | (pp_refuse_o === 1'b1);
      @(posedge clock_i);
    end
    chk(seen, refuse);
    chk(pp_allow_o, !refuse);
  endtask

  // Waits, bounded, for the erase to finish.
  task automatic wait_erase();
    int n;
    n = 0;
    while (erase_req_o === 1'b1 && n < 100)
    begin
      @(posedge clock_i);
      n++;
    end
    #1 chk(erase_req_o, 0);
  endtask

  // Control 45h: debugger retries harmlessly, third boot failure erases, then a match opens.
  task automatic t_erase_on_fail();
    load(8'h45, ID_A, 32'h0);
    pp_try(1'b1);
    connect(1'b0);
    chk(code_ready_o, 1);
    try_code(ID_B, 0);
    chk({auth_fail_o, dbg_link_o, erase_req_o}, 3'b100);
    try_code(ID_A, 1);
    chk(dbg_link_o, 1);
    connect(1'b1);
    chk(code_ready_o, 1);
    for (int k = 1; k <= 3; k++)
    begin
      try_code(ID_B, 0);
      chk({auth_fail_o, boot_access_o, erase_req_o}, {2'b10, k == 3});
    end
    wait_erase();
    connect(1'b1);
    try_code(ID_A, 0);
    chk(boot_access_o, 1);
    $display("t_erase_on_fail done");
  endtask

  // Control 52h with an ordinary code: unlimited retries, no erase, slow host still succeeds.
  task automatic t_retry_forever();
    load(8'h52, ID_A, 32'h01020304);
    pp_try(1'b0);
    connect(1'b1);
    chk(code_ready_o, 1);
    repeat (4)
    begin
      try_code(ID_B, 0);
      chk({auth_fail_o, boot_access_o, erase_req_o}, 3'b100);
    end
    try_code(ID_A, 3);
    chk(boot_access_o, 1);
    $display("t_retry_forever done");
  endtask

  // Control 52h with the reserved code: even the stored code itself never matches.
  task automatic t_locked();
    load(8'h52, RSV, 32'h0);
    connect(1'b1);
    try_code(RSV, 0);
    chk({auth_fail_o, boot_access_o, erase_req_o}, 3'b100);
    load(8'h52, RSV, 32'h0);
    connect(1'b0);
    try_code(RSV, 0);
    chk({auth_fail_o, dbg_link_o}, 2'b10);
    $display("t_locked done");
  endtask

  // Any other control code: boot entry erases without asking, then opens access.
  task automatic t_no_auth();
    load(8'hff, ID_A, 32'hffffffff);
    connect(1'b1);
    chk({erase_req_o, code_ready_o}, 2'b10);
    wait_erase();
    chk(boot_access_o, 1);
    // Without authentication a debugger links on its connect alone.
    load(8'hff, ID_A, 32'hffffffff);
    connect(1'b0);
    chk({dbg_link_o, code_ready_o, erase_req_o}, 3'b100);
    $display("t_no_auth done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence.
  initial
  begin
    n_fail  = 0;
    n_tests = 0;
    t_erase_on_fail();
    t_retry_forever();
    t_locked();
    t_no_auth();
    close_out();
  end

  // The tests need under 1,000 cycles; a hang is cut off well beyond that.
  initial
  begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    close_out();
  end
endmodule  // tb_flash_id_auth_guard
